// file: hdl/stpf_top.v
// Purpose: Spanning tree port state gate with Wishbone registers
// Assumes: Frame kind and strobes come from logic on ref_clk_i
// Notes: One port; verdicts appear one cycle after each strobe
// Function
// - After reset or startup, an enabled port sits in discarding first.
// - Discarding port that heard no control frame moves to learning at forward delay.
// - Discarding drops data both ways and learns no addresses.
// - Discarding passes received control frames to CPU, sends none from CPU; code still sends CPU link aggregation frames.
// - Learning entered only from discarding, goes forwarding at forward delay expiry.
// - Learning drops data from segment and from other ports.
// - Learning records source address of arriving frames.
// - Learning passes control frames to CPU and transmits CPU control frames.
// - Forwarding passes data from segment and from other ports.
// - Forwarding keeps learning source addresses.
// - Forwarding passes control frames both ways with the CPU.
// - Forwarding accepts management frames and passes them for a response.
// - Disabled drops all data, learns nothing, no control frames either way.
// - Discarding port silent beyond maximum age heads toward forwarding.
// - At defaults, fifty silent seconds to forwarding; each control frame heard while discarding restarts it; code restarts it only on spanning tree frames.
// - Fixed duplex disables negotiation; fixed full duplex skips carrier sense.
// - Before forwarding only spanning tree and link aggregation frames pass.
// - Forward delay programmable from 4 to 30 seconds.
// - Disabled returns to discarding first; forwarding may go discarding or disabled.
`timescale 1ns/10ps
`include "stpf_map.vh"

module stpf_top #(
  parameter [`STPF_DIV_W-1:0] SEC_CYCLES = `STPF_SEC_CYCLES
) (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire rx_valid_i,
  input wire [1:0] rx_kind_i,
  input wire [47:0] rx_src_addr_i,
  output wire rx_done_o,
  output wire rx_fwd_o,
  output wire rx_cpu_o,
  output wire learn_o,
  output wire [47:0] learn_addr_o,
  input wire tx_valid_i,
  input wire [1:0] tx_kind_i,
  output wire tx_done_o,
  output wire tx_pass_o,
  output wire [1:0] port_state_o,
  output wire autoneg_en_o,
  output wire carrier_sense_en_o
);

// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
reg [4:0] ctrl_reg;
reg [`STPF_TMR_W-1:0] fwd_delay_reg;
reg [`STPF_TMR_W-1:0] max_age_reg;
reg [15:0] drop_cnt_reg;
reg [31:0] rdata_reg;
reg ack_reg;
reg [1:0] state_reg;
reg [1:0] state_next;
reg heard_reg;
reg aged_reg;
reg [`STPF_DIV_W-1:0] div_reg;
reg tick_reg;
reg rx_done_reg;
reg rx_fwd_reg;
reg rx_cpu_reg;
reg learn_reg;
reg [47:0] learn_addr_reg;
reg tx_done_reg;
reg tx_pass_reg;
reg boot_reg;
wire wb_req;
wire wb_wr;
wire stp_en;
wire restart;
wire bypass;
wire rx_bpdu;
wire fwd_exp;
wire age_exp;
wire fwd_start;
wire fwd_run;
wire age_start;
wire age_run;
wire data_ok;
wire rx_fwd_c;
wire rx_cpu_c;
wire tx_pass_c;
wire drop_c;

// ----------------------------------------------------------------
// Wishbone slave
// ----------------------------------------------------------------
assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
assign stp_en = ctrl_reg[`STPF_CTRL_STP_EN];
assign restart = wb_wr && (wb_adr_i == `STPF_OFS_CTRL) && wb_dat_i[`STPF_CTRL_RESTART];

// Clamp a written timer value into its legal range
function [`STPF_TMR_W-1:0] clamp;
  input [`STPF_TMR_W-1:0] v;
  input [`STPF_TMR_W-1:0] lo;
  input [`STPF_TMR_W-1:0] hi;
  begin
    if (v < lo)
      clamp = lo;
    else if (v > hi)
      clamp = hi;
    else
      clamp = v;
  end
endfunction

// Register writes and one-cycle ack; unmapped writes are ignored
always @(posedge ref_clk_i or negedge resetn_i)
begin
  if (!resetn_i)
  begin
    ctrl_reg <= `STPF_CTRL_RST;
    fwd_delay_reg <= `STPF_FWD_DELAY_RST_S;
    max_age_reg <= `STPF_MAX_AGE_RST_S;
    ack_reg <= 1'b0;
  end
  else
  begin
    ack_reg <= wb_req;
    if (wb_wr)
    begin
      if (wb_adr_i == `STPF_OFS_CTRL)
        ctrl_reg <= {wb_dat_i[4:3], 1'b0, wb_dat_i[1:0]}; // Restart bit self-clears
      else if (wb_adr_i == `STPF_OFS_FWD_DELAY)
        fwd_delay_reg <= clamp(wb_dat_i[5:0], `STPF_FWD_DELAY_MIN_S, `STPF_FWD_DELAY_MAX_S);
      else if (wb_adr_i == `STPF_OFS_MAX_AGE)
        max_age_reg <= clamp(wb_dat_i[5:0], `STPF_MAX_AGE_MIN_S, `STPF_MAX_AGE_MAX_S);
    end
  end
end

// Read mux, captured with the ack; unmapped reads as zero
always @(posedge ref_clk_i or negedge resetn_i)
begin
  if (!resetn_i)
    rdata_reg <= 32'h00000000;
  else if (wb_req && !wb_we_i)
  begin
    if (wb_adr_i == `STPF_OFS_CTRL)
      rdata_reg <= {27'h0000000, ctrl_reg};
    else if (wb_adr_i == `STPF_OFS_FWD_DELAY)
      rdata_reg <= {26'h0000000, fwd_delay_reg};
    else if (wb_adr_i == `STPF_OFS_MAX_AGE)
      rdata_reg <= {26'h0000000, max_age_reg};
    else if (wb_adr_i == `STPF_OFS_STATUS)
      rdata_reg <= {28'h0000000, aged_reg, heard_reg, state_reg};
    else if (wb_adr_i == `STPF_OFS_DROP_CNT)
      rdata_reg <= {16'h0000, drop_cnt_reg};
    else
      rdata_reg <= 32'h00000000;
  end
end

assign wb_dat_o = rdata_reg;
assign wb_ack_o = ack_reg;

// ----------------------------------------------------------------
// One-second tick
// ----------------------------------------------------------------
// Free running, so a restarted timer may run up to one second short
always @(posedge ref_clk_i or negedge resetn_i)
begin
  if (!resetn_i)
  begin
    div_reg <= {`STPF_DIV_W{1'b0}};
    tick_reg <= 1'b0;
  end
  else
  begin
    tick_reg <= (div_reg == SEC_CYCLES - {{(`STPF_DIV_W-1){1'b0}}, 1'b1});
    if (div_reg == SEC_CYCLES - {{(`STPF_DIV_W-1){1'b0}}, 1'b1})
      div_reg <= {`STPF_DIV_W{1'b0}};
    else
      div_reg <= div_reg + {{(`STPF_DIV_W-1){1'b0}}, 1'b1};
  end
end

// ----------------------------------------------------------------
// Timers
// ----------------------------------------------------------------
assign rx_bpdu = rx_valid_i && (rx_kind_i == `STPF_KIND_BPDU);

// Forward delay restarts on each entry to discarding or learning, and once after reset
assign fwd_start = ((state_next != state_reg) &&
                   ((state_next == `STPF_ST_DISCARD) || (state_next == `STPF_ST_LEARN))) ||
                   restart || !stp_en || age_exp || boot_reg;
// Discarding waits here only when no neighbour was heard or it aged out
assign fwd_run = (state_reg == `STPF_ST_LEARN) ||
                 ((state_reg == `STPF_ST_DISCARD) && (!heard_reg || aged_reg));
// Every spanning tree frame heard while discarding restarts the age timer
assign age_start = rx_bpdu && (state_reg == `STPF_ST_DISCARD);
assign age_run = (state_reg == `STPF_ST_DISCARD) && heard_reg && !aged_reg;

stpf_timer u_fwd_tmr (
  .ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i),
  .tick_i(tick_reg),
  .start_i(fwd_start),
  .run_i(fwd_run),
  .load_i(fwd_delay_reg),
  .expired_o(fwd_exp)
);

stpf_timer u_age_tmr (
  .ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i),
  .tick_i(tick_reg),
  .start_i(age_start),
  .run_i(age_run),
  .load_i(max_age_reg),
  .expired_o(age_exp)
);

// ----------------------------------------------------------------
// Port state machine
// ----------------------------------------------------------------
always @*
begin
  state_next = state_reg;
  if (!stp_en || restart)
    state_next = `STPF_ST_DISCARD;
  else if (ctrl_reg[`STPF_CTRL_DISABLE])
    state_next = `STPF_ST_DISABLED;
  else
    case (state_reg)
      `STPF_ST_DISCARD:
        if (fwd_exp && fwd_run && !rx_bpdu)
          state_next = `STPF_ST_LEARN;
      `STPF_ST_LEARN:
        if (fwd_exp)
          state_next = `STPF_ST_FORWARD;
      `STPF_ST_FORWARD:
        state_next = `STPF_ST_FORWARD;
      default:
        state_next = `STPF_ST_DISCARD;
    endcase
end

// State plus heard and aged flags; a frame wins over an expiry
always @(posedge ref_clk_i or negedge resetn_i)
begin
  if (!resetn_i)
  begin
    state_reg <= `STPF_ST_DISCARD;
    heard_reg <= 1'b0;
    aged_reg <= 1'b0;
    boot_reg <= 1'b1; // Timer is empty at reset, so load it once
  end
  else
  begin
    boot_reg <= 1'b0;
    state_reg <= state_next;
    if (state_next != `STPF_ST_DISCARD || state_reg != `STPF_ST_DISCARD)
    begin
      heard_reg <= 1'b0;
      aged_reg <= 1'b0;
    end
    else if (age_start)
    begin
      heard_reg <= 1'b1;
      aged_reg <= 1'b0;
    end
    else if (age_exp)
      aged_reg <= 1'b1;
  end
end

// ----------------------------------------------------------------
// Frame verdicts
// ----------------------------------------------------------------
// With spanning tree off the port is a plain switch port
assign bypass = !stp_en;
assign data_ok = bypass || (state_reg == `STPF_ST_FORWARD);
assign rx_fwd_c = (rx_kind_i == `STPF_KIND_DATA) && data_ok;
// Control frames reach the CPU in every state but disabled
assign rx_cpu_c = (((rx_kind_i == `STPF_KIND_BPDU) || (rx_kind_i == `STPF_KIND_LAGG)) &&
                  (state_reg != `STPF_ST_DISABLED)) ||
                  ((rx_kind_i == `STPF_KIND_MGMT) && data_ok);
// CPU spanning tree frames leave only once learning has begun
assign tx_pass_c = ((tx_kind_i == `STPF_KIND_DATA) && data_ok) ||
                   ((tx_kind_i == `STPF_KIND_BPDU) && !bypass &&
                    ((state_reg == `STPF_ST_LEARN) || (state_reg == `STPF_ST_FORWARD))) ||
                   ((tx_kind_i == `STPF_KIND_LAGG) && (state_reg != `STPF_ST_DISABLED)) ||
                   ((tx_kind_i == `STPF_KIND_MGMT) && data_ok);
assign drop_c = (rx_valid_i && !rx_fwd_c && !rx_cpu_c) || (tx_valid_i && !tx_pass_c);

// Registered verdicts, one cycle after the strobe
always @(posedge ref_clk_i or negedge resetn_i)
begin
  if (!resetn_i)
  begin
    rx_done_reg <= 1'b0;
    rx_fwd_reg <= 1'b0;
    rx_cpu_reg <= 1'b0;
    learn_reg <= 1'b0;
    learn_addr_reg <= 48'h000000000000;
    tx_done_reg <= 1'b0;
    tx_pass_reg <= 1'b0;
  end
  else
  begin
    rx_done_reg <= rx_valid_i;
    rx_fwd_reg <= rx_valid_i && rx_fwd_c;
    rx_cpu_reg <= rx_valid_i && rx_cpu_c;
    learn_reg <= rx_valid_i && (rx_kind_i == `STPF_KIND_DATA) &&
                 (bypass || (state_reg == `STPF_ST_LEARN) || (state_reg == `STPF_ST_FORWARD));
    if (rx_valid_i)
      learn_addr_reg <= rx_src_addr_i;
    tx_done_reg <= tx_valid_i;
    tx_pass_reg <= tx_valid_i && tx_pass_c;
  end
end

// Drop counter; a write clears it, but a drop that cycle still counts
always @(posedge ref_clk_i or negedge resetn_i)
begin
  if (!resetn_i)
    drop_cnt_reg <= 16'h0000;
  else if (wb_wr && (wb_adr_i == `STPF_OFS_DROP_CNT))
    drop_cnt_reg <= {15'h0000, drop_c};
  else if (drop_c && (drop_cnt_reg != 16'hffff))
    drop_cnt_reg <= drop_cnt_reg + 16'h0001;
end

// ----------------------------------------------------------------
// Outputs
// ----------------------------------------------------------------
assign rx_done_o = rx_done_reg;
assign rx_fwd_o = rx_fwd_reg;
assign rx_cpu_o = rx_cpu_reg;
assign learn_o = learn_reg;
assign learn_addr_o = learn_addr_reg;
assign tx_done_o = tx_done_reg;
assign tx_pass_o = tx_pass_reg;
assign port_state_o = state_reg;
// Fixed duplex never negotiates; fixed full never senses carrier
assign autoneg_en_o = !ctrl_reg[`STPF_CTRL_DPX_FIXED];
assign carrier_sense_en_o = !(ctrl_reg[`STPF_CTRL_DPX_FIXED] && ctrl_reg[`STPF_CTRL_DPX_FULL]);

endmodule // stpf_top

// file: common/stpf_map.vh
// Purpose: Constants for the spanning tree port state gate
// Assumes: 25 MHz ref_clk_i, timers counted in whole seconds
// Notes: Byte offsets of the Wishbone register words
`ifndef STPF_MAP_VH
`define STPF_MAP_VH

// ----------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------
`define STPF_CLK_HZ 25000000
`define STPF_TICK_S 1
`define STPF_SEC_CYCLES (`STPF_CLK_HZ * `STPF_TICK_S)
`define STPF_DIV_W 25

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define STPF_OFS_CTRL 8'h00
`define STPF_OFS_FWD_DELAY 8'h04
`define STPF_OFS_MAX_AGE 8'h08
`define STPF_OFS_STATUS 8'h0c
`define STPF_OFS_DROP_CNT 8'h10

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define STPF_CTRL_STP_EN 0
`define STPF_CTRL_DISABLE 1
`define STPF_CTRL_RESTART 2
`define STPF_CTRL_DPX_FIXED 3
`define STPF_CTRL_DPX_FULL 4
`define STPF_CTRL_RST 5'h01

// ----------------------------------------------------------------
// Timer limits in seconds
// ----------------------------------------------------------------
`define STPF_TMR_W 6
`define STPF_FWD_DELAY_MIN_S 6'h04
`define STPF_FWD_DELAY_MAX_S 6'h1e
`define STPF_FWD_DELAY_RST_S 6'h0f
`define STPF_MAX_AGE_MIN_S 6'h06
`define STPF_MAX_AGE_MAX_S 6'h28
`define STPF_MAX_AGE_RST_S 6'h14

// ----------------------------------------------------------------
// Port states
// ----------------------------------------------------------------
`define STPF_ST_DISCARD 2'h0
`define STPF_ST_LEARN 2'h1
`define STPF_ST_FORWARD 2'h2
`define STPF_ST_DISABLED 2'h3

// ----------------------------------------------------------------
// Frame kinds
// ----------------------------------------------------------------
`define STPF_KIND_DATA 2'h0
`define STPF_KIND_BPDU 2'h1
`define STPF_KIND_LAGG 2'h2
`define STPF_KIND_MGMT 2'h3

`endif

// file: hdl/stpf_timer.v
// Purpose: Seconds down-counter with one-cycle expiry pulse
// Assumes: tick_i is a one-cycle pulse once per second
// Notes: Start reloads and wins over a running count
`timescale 1ns/10ps
`include "stpf_map.vh"

module stpf_timer (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire tick_i,
  input wire start_i,
  input wire run_i,
  input wire [`STPF_TMR_W-1:0] load_i,
  output wire expired_o
);

reg [`STPF_TMR_W-1:0] cnt_reg;
reg exp_reg;

// ----------------------------------------------------------------
// Count down on ticks while running
// ----------------------------------------------------------------
always @(posedge ref_clk_i or negedge resetn_i)
begin
  if (!resetn_i)
  begin
    cnt_reg <= {`STPF_TMR_W{1'b0}};
    exp_reg <= 1'b0;
  end
  else
  begin
    exp_reg <= 1'b0;
    if (start_i)
      cnt_reg <= load_i;
    else if (run_i && tick_i && (cnt_reg != {`STPF_TMR_W{1'b0}}))
    begin
      cnt_reg <= cnt_reg - {{(`STPF_TMR_W-1){1'b0}}, 1'b1};
      exp_reg <= (cnt_reg == {{(`STPF_TMR_W-1){1'b0}}, 1'b1}); // Last second
    end
  end
end

assign expired_o = exp_reg;

endmodule // stpf_timer

// file: tb/stpf_checker.sv
// Purpose: Port assertions for the spanning tree state gate
// Assumes: Bound to stpf_top, single clock, STP kept enabled
// Notes: Each property ties an output to its cause at the inputs, at other outputs or at its own earlier value
`timescale 1ns/10ps
`include "stpf_map.vh"

module stpf_checker #(
  parameter [`STPF_DIV_W-1:0] SEC_CYCLES = `STPF_SEC_CYCLES
) (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire rx_valid_i,
  input wire [1:0] rx_kind_i,
  input wire [47:0] rx_src_addr_i,
  input wire rx_done_o,
  input wire rx_fwd_o,
  input wire rx_cpu_o,
  input wire learn_o,
  input wire [47:0] learn_addr_o,
  input wire tx_valid_i,
  input wire [1:0] tx_kind_i,
  input wire tx_done_o,
  input wire tx_pass_o,
  input wire [1:0] port_state_o,
  input wire autoneg_en_o,
  input wire carrier_sense_en_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking dcb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Data frame strobe, shared by several properties
  wire rx_data = rx_valid_i && (rx_kind_i == `STPF_KIND_DATA);

  ack_one_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse one cycle after request");
  verdict_due_a: assert property (rx_valid_i && tx_valid_i |=> rx_done_o && tx_done_o)
    else $error("frame verdict missing one cycle after strobe");
  early_drop_a: assert property (rx_data && port_state_o != `STPF_ST_FORWARD |=> !rx_fwd_o)
    else $error("data forwarded before forwarding state");
  fwd_pass_a: assert property (rx_data && port_state_o == `STPF_ST_FORWARD |=> rx_fwd_o && learn_o)
    else $error("forwarding state failed to pass or learn data");
  learn_addr_a: assert property (rx_data && port_state_o inside {`STPF_ST_LEARN, `STPF_ST_FORWARD}
    |=> learn_o && learn_addr_o == $past(rx_src_addr_i))
    else $error("learned address differs from frame source");
  dis_quiet_a: assert property (port_state_o == `STPF_ST_DISABLED
    |=> !(rx_fwd_o || rx_cpu_o || learn_o || tx_pass_o))
    else $error("disabled port let a frame through");
  disc_ctrl_a: assert property (rx_valid_i && tx_valid_i && rx_kind_i == `STPF_KIND_BPDU
    && tx_kind_i == `STPF_KIND_BPDU && port_state_o == `STPF_ST_DISCARD |=> rx_cpu_o && !tx_pass_o)
    else $error("discarding control frame handling wrong");
  learn_entry_a: assert property ($changed(port_state_o) && port_state_o == `STPF_ST_LEARN
    |-> $past(port_state_o) == `STPF_ST_DISCARD)
    else $error("learning entered from a state other than discarding");
  dis_exit_a: assert property ($past(port_state_o) == `STPF_ST_DISABLED
    && port_state_o != `STPF_ST_DISABLED |-> port_state_o == `STPF_ST_DISCARD)
    else $error("disabled port left to a state other than discarding");
  duplex_a: assert property (!carrier_sense_en_o |-> !autoneg_en_o)
    else $error("carrier sense off while negotiation on");

  // Main scenarios reached
  cover property (port_state_o == `STPF_ST_FORWARD && rx_fwd_o);
  cover property ($past(port_state_o) == `STPF_ST_LEARN && port_state_o == `STPF_ST_FORWARD);
  cover property (port_state_o == `STPF_ST_DISABLED && tx_valid_i);
endmodule // stpf_checker

bind stpf_top stpf_checker #(.SEC_CYCLES(SEC_CYCLES)) i_stpf_checker (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid_i), .rx_kind_i(rx_kind_i), .rx_src_addr_i(rx_src_addr_i),
  .rx_done_o(rx_done_o), .rx_fwd_o(rx_fwd_o), .rx_cpu_o(rx_cpu_o), .learn_o(learn_o),
  .learn_addr_o(learn_addr_o), .tx_valid_i(tx_valid_i), .tx_kind_i(tx_kind_i), .tx_done_o(tx_done_o),
  .tx_pass_o(tx_pass_o), .port_state_o(port_state_o), .autoneg_en_o(autoneg_en_o),
  .carrier_sense_en_o(carrier_sense_en_o));

// file: tb/stpf_nbr_model.sv
// Purpose: Neighbouring bridge on the segment, drives received frames
// Assumes: Same clock as the gate, one frame per cycle at most
// Notes: Idle lines show inverted last value, never a stale frame
`timescale 1ns/10ps
`include "stpf_map.vh"

module stpf_nbr_model #(
  parameter [7:0] HELLO = 8'h14
) (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire send_i,
  input wire [1:0] send_kind_i,
  input wire [47:0] send_addr_i,
  input wire hello_en_i,
  output reg rx_valid_o,
  output reg [1:0] rx_kind_o,
  output reg [47:0] rx_src_addr_o
);
  // ----------------------------------------------------------------
  // Frame source
  // ----------------------------------------------------------------
  reg [7:0] gap_reg;

  // Bench frames win; hello gap restarts when hellos are switched off
  always @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      gap_reg <= 8'h00;
      rx_valid_o <= 1'b0;
      rx_kind_o <= 2'h0;
      rx_src_addr_o <= 48'h0;
    end
    else if (send_i)
    begin
      rx_valid_o <= 1'b1;
      rx_kind_o <= send_kind_i;
      rx_src_addr_o <= send_addr_i;
    end
    else if (hello_en_i && gap_reg == HELLO)
    begin
      gap_reg <= 8'h00;
      rx_valid_o <= 1'b1;
      rx_kind_o <= `STPF_KIND_BPDU;
      rx_src_addr_o <= 48'h02bb00000001;
    end
    else
    begin
      gap_reg <= hello_en_i ? gap_reg + 8'h01 : 8'h00;
      rx_valid_o <= 1'b0;
      rx_kind_o <= ~rx_kind_o;
      rx_src_addr_o <= ~rx_src_addr_o;
    end
  end
endmodule // stpf_nbr_model

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the spanning tree state gate
// Assumes: One second scaled to 8 cycles so timers run short
// Notes: Timing windows allow for the free-running second tick
`timescale 1ns/10ps
`include "stpf_map.vh"

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_top;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, rxv, txv = 0, send = 0, hello = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wdat = 0, rdat, q;
  logic [1:0] rxk, txk = 0, skind = 0, st;
  logic [47:0] rxa, saddr = 0, laddr;
  logic ack, rdone, rfwd, rcpu, lrn, tdone, tpass, aneg, csen;
  int n_errors = 0, checks_done = 0, cnt = 0, t0 = 0;

  always #20 clk = ~clk;
  always @(posedge clk) cnt <= cnt + 1;

  stpf_top #(.SEC_CYCLES(25'd8)) i_stpf_top (.ref_clk_i(clk), .resetn_i(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rx_valid_i(rxv), .rx_kind_i(rxk), .rx_src_addr_i(rxa), .rx_done_o(rdone),
    .rx_fwd_o(rfwd), .rx_cpu_o(rcpu), .learn_o(lrn), .learn_addr_o(laddr), .tx_valid_i(txv),
    .tx_kind_i(txk), .tx_done_o(tdone), .tx_pass_o(tpass), .port_state_o(st), .autoneg_en_o(aneg),
    .carrier_sense_en_o(csen));
  stpf_nbr_model i_stpf_nbr_model (.ref_clk_i(clk), .resetn_i(rstn), .send_i(send), .send_kind_i(skind),
    .send_addr_i(saddr), .hello_en_i(hello), .rx_valid_o(rxv), .rx_kind_o(rxk), .rx_src_addr_o(rxa));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Classic cycle; released only after the edge that samples ack
  task wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    begin
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      @(posedge clk);
      // No cycle count assumed; only the watchdog ends a hung wait
      while (ack !== 1'b1)
        @(posedge clk);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb_cycle(1'b1, a, d, 4'hf);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    begin
      wb_cycle(1'b0, a, 32'h0, 4'hf);
      `CHK(q, e)
    end
  endtask
  // Expected verdict bits {rx_done, fwd, cpu, learn, tx_done, pass}
  function automatic logic [5:0] verdict(input logic [1:0] s, input logic [1:0] k);
    logic fw, ds, ln;
    begin
      fw = (s == `STPF_ST_FORWARD);
      ds = (s == `STPF_ST_DISABLED);
      ln = (s == `STPF_ST_LEARN) || fw;
      case (k)
        `STPF_KIND_DATA: verdict = {1'b1, fw, 1'b0, ln, 1'b1, fw};
        `STPF_KIND_BPDU: verdict = {1'b1, 1'b0, !ds, 1'b0, 1'b1, ln};
        `STPF_KIND_LAGG: verdict = {1'b1, 1'b0, !ds, 1'b0, 1'b1, !ds};
        default: verdict = {1'b1, 1'b0, fw, 1'b0, 1'b1, fw};
      endcase
    end
  endfunction
  // Same kind both ways; rx lags tx by the neighbour's one cycle
  task frame(input logic [1:0] k, input logic [1:0] s);
    logic [5:0] got;
    begin
      send <= 1'b1;
      skind <= k;
      saddr <= 48'h02aa00000000 + k;
      txv <= 1'b1;
      txk <= k;
      @(posedge clk);
      send <= 1'b0;
      txv <= 1'b0;
      @(posedge clk);
      got[1:0] = {tdone, tpass};
      @(posedge clk);
      got[5:2] = {rdone, rfwd, rcpu, lrn};
      `CHK(got, verdict(s, k))
      if (k == `STPF_KIND_DATA && s inside {`STPF_ST_LEARN, `STPF_ST_FORWARD})
        `CHK(laddr, 48'h02aa00000000)
    end
  endtask
  task sweep(input logic [1:0] s);
    for (int k = 0; k < 4; k++) frame(k[1:0], s);
  endtask
  // Cycles from t0 until the state is reached must lie in [lo, hi]
  task wait_state(input logic [1:0] s, input int lo, input int hi);
    begin
      while (st !== s && cnt - t0 < hi + 10) @(posedge clk);
      `CHK(cnt - t0 >= lo && cnt - t0 <= hi, 1'b1)
      t0 = cnt;
    end
  endtask
  task report_and_stop;
    begin
      $display("errors=%0d checks=%0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  // Scaled times: forward delay 4 s = 32 cycles, max age 6 s = 48
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    `CHK({st, aneg, csen}, {`STPF_ST_DISCARD, 2'b11})
    rd_chk(`STPF_OFS_CTRL, 32'h1);
    rd_chk(`STPF_OFS_MAX_AGE, 32'h14);
    rd_chk(`STPF_OFS_STATUS, 32'h0);
    rd_chk(`STPF_OFS_DROP_CNT, 32'h0);
    rd_chk(8'h20, 32'h0);
    rd_chk(`STPF_OFS_FWD_DELAY, 32'h0f);
    wr(`STPF_OFS_FWD_DELAY, 32'h2);
    rd_chk(`STPF_OFS_FWD_DELAY, 32'h4);
    wr(`STPF_OFS_FWD_DELAY, 32'h3f);
    rd_chk(`STPF_OFS_FWD_DELAY, 32'h1e);
    wb_cycle(1'b1, `STPF_OFS_FWD_DELAY, 32'h5, 4'he);
    rd_chk(`STPF_OFS_FWD_DELAY, 32'h1e);
    wr(`STPF_OFS_FWD_DELAY, 32'h4);
    wr(`STPF_OFS_MAX_AGE, 32'h6);
    wr(`STPF_OFS_CTRL, 32'h5);
    t0 = cnt;
    wait_state(`STPF_ST_LEARN, 20, 36);
    sweep(`STPF_ST_LEARN);
    wait_state(`STPF_ST_FORWARD, 22, 36);
    sweep(`STPF_ST_FORWARD);
    repeat (100) @(posedge clk);
    `CHK(st, `STPF_ST_FORWARD)
    wr(`STPF_OFS_CTRL, 32'h3);
    `CHK(st, `STPF_ST_DISABLED)
    // Clear the drop count so that the disabled sweep's drops stand alone
    wr(`STPF_OFS_DROP_CNT, 32'h0);
    sweep(`STPF_ST_DISABLED);
    rd_chk(`STPF_OFS_DROP_CNT, 32'h8);
    wr(`STPF_OFS_CTRL, 32'h1);
    `CHK(st, `STPF_ST_DISCARD)
    hello <= 1'b1;
    sweep(`STPF_ST_DISCARD);
    repeat (200) @(posedge clk);
    `CHK(st, `STPF_ST_DISCARD)
    hello <= 1'b0;
    t0 = cnt;
    wait_state(`STPF_ST_LEARN, 40, 86);
    wait_state(`STPF_ST_FORWARD, 22, 36);
    wr(`STPF_OFS_CTRL, 32'h9);
    `CHK({aneg, csen}, 2'b01)
    wr(`STPF_OFS_CTRL, 32'h19);
    `CHK({aneg, csen}, 2'b00)
    report_and_stop;
  end

  // Whole run is near 600 cycles; cut off well beyond it
  initial
  begin
    #240000;
    n_errors++;
    report_and_stop;
  end
endmodule // tb_top
